// File: fsch_host_model.sv
// Host side of the serial link: select, clock, hold and data-in pins.
// Assumes the bench calls its tasks; the clock stands still outside frames.
`timescale 1ns/1ns
module fsch_host_model (
  // Link pins
  output fsch_pkg::fsch_pins_t pins_o
);
  initial begin
    pins_o = 4'hA;
  end
  // Deselect shows a changed data line, never the last value
  task automatic sel(input logic v);
    #30;
    pins_o.si   = ~pins_o.si;
    pins_o.ce_n = v;
  endtask
  task automatic set_sck(input logic v);
    #30;
    pins_o.sck = v;
  endtask
  task automatic set_hold(input logic v);
    #30;
    pins_o.hold_n = v;
  endtask
  // 800 ns periods, clock left low
  task automatic tick(input int n);
    repeat (n) begin
      pins_o.si = ~pins_o.si;
      #400 pins_o.sck = 1'b1;
      #400 pins_o.sck = 1'b0;
    end
  endtask
  task automatic rejoin();
    set_hold(1'b1);
    #400;
    sel(1'b0);
  endtask
endmodule

// File: fsch_pkg.sv
// Constants, types and register layout for the flash status/config/hold block.
// Assumes one 10 MHz system clock; link pins are sampled, not clocked on.
package fsch_pkg;
  // ***************
  // Register map
  // ***************
  localparam logic [3:0] ADR_STATUS = 4'h0;
  localparam logic [3:0] ADR_CONFIG = 4'h4;
  localparam logic [3:0] ADR_CMD    = 4'h8;
  localparam logic [3:0] ADR_SID    = 4'hC;
  // Status bit positions
  localparam int ST_BUSY0 = 0;
  localparam int ST_WEL   = 1;
  localparam int ST_ESUSP = 2;
  localparam int ST_PSUSP = 3;
  localparam int ST_LKDN  = 4;
  localparam int ST_SEC   = 5;
  localparam int ST_BUSY7 = 7;
  // Config bit positions
  localparam int CF_PINCFG = 1;
  localparam int CF_NOPERM = 3;
  localparam int CF_PROTECT_PIN_ENABLE   = 7;
  localparam logic [7:0] CF_WR_MASK = 8'h82;
  // Command register fields
  localparam int CMD_ADDR_LSB = 8;
  localparam int CMD_DATA_LSB = 24;
  // ***************
  // Secure id space
  // ***************
  localparam int SID_BYTES = 2048;
  localparam int SID_AW    = 11;
  localparam logic [SID_AW-1:0] SID_FACT_END = 11'h008;
  localparam logic [7:0] SID_BLANK = 8'hFF;
  // ***************
  // Timing
  // ***************
  localparam int CLK_MHZ    = 10;
  localparam int T_PROTECT_PIN_ENABLE_US  = 10;
  localparam int PROTECT_PIN_ENABLE_CYC   = T_PROTECT_PIN_ENABLE_US * CLK_MHZ;
  localparam int TMR_W      = 8;
  // ***************
  // Types
  // ***************
  typedef enum logic [3:0] {
    CMD_NONE    = 4'h0,
    CMD_WREN    = 4'h1,
    CMD_WRITE_DISABLE_CMD    = 4'h2,
    CMD_LOCKDN  = 4'h3,
    CMD_LOCKOUT_SECURE_ID_CMD    = 4'h4,
    CMD_PROGRAM_SECURE_ID_CMD    = 4'h5,
    CMD_SUSPEND = 4'h6,
    CMD_RESUME  = 4'h7,
    CMD_RESET   = 4'h8,
    CMD_WBPR    = 4'h9
  } fsch_cmd_t;
  typedef enum logic [1:0] {
    HS_RUN   = 2'b01,
    HS_PAUSE = 2'b10
  } fsch_hold_t;
  typedef enum logic [1:0] {
    OP_NONE = 2'h0,
    OP_PROG = 2'h1,
    OP_ERAS = 2'h2
  } fsch_op_t;
  typedef struct packed {
    logic ce_n;
    logic sck;
    logic hold_n;
    logic si;
  } fsch_pins_t;
endpackage

// File: fsch_top.sv
// Status/config registers, secure id space and hold pause of a serial flash.
// Assumes engine signals on CLK_I; link pins are asynchronous and synchronised.
`timescale 1ns/1ns
module fsch_top #(
  parameter logic [63:0] FACTORY_UID = 64'h0123456789ABCDEF  // Arbitrary value
) (
  // Clock and reset
  input  wire logic        CLK_I,
  input  wire logic        RST_N_I,
  // Avalon-MM slave
  input  wire logic [3:0]  AVS_ADDRESS_I,
  input  wire logic        AVS_READ_I,
  input  wire logic        AVS_WRITE_I,
  input  wire logic [31:0] AVS_WRITEDATA_I,
  output logic      [31:0] AVS_READDATA_O,
  output logic             AVS_WAITREQUEST_O,
  // Serial link pins
  input  wire logic        SPI_CE_N_I,
  input  wire logic        SPI_SCK_I,
  input  wire logic        SPI_HOLD_N_I,
  input  wire logic        SPI_SI_I,
  output logic             SPI_SO_O,
  output logic             SPI_SO_OE_O,
  // Command core side
  input  wire logic        QUAD_MODE_I,
  input  wire logic        SO_DATA_I,
  input  wire logic        SO_DRIVE_I,
  output logic             SI_O,
  output logic             SCK_RISE_O,
  output logic             IF_RESET_O,
  output logic             HOLD_ACTIVE_O,
  output logic             QUAD_ALLOW_O,
  // Array engine side
  input  wire logic        ENG_BUSY_I,
  input  wire logic [1:0]  ENG_OP_I,
  input  wire logic        ENG_DONE_I,
  input  wire logic        PERM_LOCKED_I,
  output logic             WRITE_ALLOW_O,
  output logic             SUSPEND_O,
  output logic             RESUME_O,
  // Non-volatile bits
  input  wire logic        SEC_NV_I,
  input  wire logic        PROTECT_PIN_ENABLE_NV_I,
  output logic             SEC_O,
  output logic             PROTECT_PIN_ENABLE_O
);
  // ***************
  // Bus slave
  // ***************
  logic        wait_ff, nxt_wait;
  logic [31:0] rdata_ff, nxt_rdata;
  logic        req, take, wr_take;
  logic [7:0]  status_b, config_b;
  logic [7:0]  sid_q;

  assign req = AVS_READ_I | AVS_WRITE_I;
  assign take = req & wait_ff;
  assign wr_take = take & AVS_WRITE_I;

  always_comb begin
    nxt_wait = ~take;
    nxt_rdata = rdata_ff;
    if (take & AVS_READ_I) begin
      if (AVS_ADDRESS_I == fsch_pkg::ADR_STATUS) begin
        nxt_rdata = {24'h000000, status_b};
      end else if (AVS_ADDRESS_I == fsch_pkg::ADR_CONFIG) begin
        nxt_rdata = {24'h000000, config_b};
      end else if (AVS_ADDRESS_I == fsch_pkg::ADR_SID) begin
        nxt_rdata = {24'h000000, sid_q};
      end else begin
        nxt_rdata = 32'h00000000;
      end
    end
  end

  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      wait_ff <= 1'b1;
      rdata_ff <= 32'h00000000;
    end else begin
      wait_ff <= nxt_wait;
      rdata_ff <= nxt_rdata;
    end
  end
  assign AVS_WAITREQUEST_O = wait_ff;
  assign AVS_READDATA_O = rdata_ff;

  // ***************
  // Command decode
  // ***************
  fsch_pkg::fsch_cmd_t cmd;
  logic [fsch_pkg::SID_AW-1:0] cmd_addr;
  logic [7:0] cmd_data;
  logic cfg_wr;

  assign cmd = (wr_take && AVS_ADDRESS_I == fsch_pkg::ADR_CMD)
             ? fsch_pkg::fsch_cmd_t'(AVS_WRITEDATA_I[3:0]) : fsch_pkg::CMD_NONE;
  assign cmd_addr = AVS_WRITEDATA_I[fsch_pkg::CMD_ADDR_LSB +: fsch_pkg::SID_AW];
  assign cmd_data = AVS_WRITEDATA_I[fsch_pkg::CMD_DATA_LSB +: 8];
  assign cfg_wr = wr_take && AVS_ADDRESS_I == fsch_pkg::ADR_CONFIG;

  // ***************
  // Status and config state
  // ***************
  logic wel_ff, nxt_wel;
  logic esusp_ff, nxt_esusp;
  logic psusp_ff, nxt_psusp;
  logic lkdn_ff, nxt_lkdn;
  logic sec_ff, nxt_sec;
  logic pincfg_ff, nxt_pincfg;
  logic protect_pin_enable_ff, nxt_protect_pin_enable;
  logic noperm_ff, nxt_noperm;
  logic init_ff, nxt_init;
  logic susp_ff, nxt_susp;
  logic resm_ff, nxt_resm;
  logic [fsch_pkg::TMR_W-1:0] tmr_ff, nxt_tmr;
  logic busy;
  logic sid_ok;

  // Secure id program passes only with latch set, unlocked and user area
  function automatic logic sid_prog_ok(input logic write_enable_latch, input logic sec,
                                       input logic [fsch_pkg::SID_AW-1:0] a);
    sid_prog_ok = write_enable_latch & ~sec & (a >= fsch_pkg::SID_FACT_END);
  endfunction

  assign busy = ENG_BUSY_I | (tmr_ff != '0);
  assign sid_ok = (cmd == fsch_pkg::CMD_PROGRAM_SECURE_ID_CMD) & ~busy & sid_prog_ok(wel_ff, sec_ff, cmd_addr);

  always_comb begin
    nxt_wel = wel_ff;
    nxt_esusp = esusp_ff;
    nxt_psusp = psusp_ff;
    nxt_lkdn = lkdn_ff;
    nxt_sec = sec_ff;
    nxt_pincfg = pincfg_ff;
    nxt_protect_pin_enable = protect_pin_enable_ff;
    nxt_noperm = ~PERM_LOCKED_I;
    nxt_init = 1'b1;
    nxt_susp = 1'b0;
    nxt_resm = 1'b0;
    nxt_tmr = (tmr_ff != '0) ? tmr_ff - 1'b1 : tmr_ff;
    // Non-volatile bits come back only once, after reset release
    if (!init_ff) begin
      nxt_sec = SEC_NV_I;
      nxt_protect_pin_enable = PROTECT_PIN_ENABLE_NV_I;
    end
    case (cmd)
      fsch_pkg::CMD_WREN: nxt_wel = 1'b1;
      fsch_pkg::CMD_WRITE_DISABLE_CMD, fsch_pkg::CMD_RESET: nxt_wel = 1'b0;
      fsch_pkg::CMD_WBPR: nxt_wel = 1'b0;
      fsch_pkg::CMD_LOCKDN: begin
        if (wel_ff) begin
          nxt_lkdn = 1'b1;
        end
        nxt_wel = 1'b0;
      end
      fsch_pkg::CMD_LOCKOUT_SECURE_ID_CMD: begin
        if (wel_ff) begin
          nxt_sec = 1'b1;
        end
        nxt_wel = 1'b0;
      end
      fsch_pkg::CMD_PROGRAM_SECURE_ID_CMD: begin
        if (sid_ok) begin
          nxt_wel = 1'b0;
        end
      end
      fsch_pkg::CMD_SUSPEND: begin
        if (ENG_BUSY_I && ENG_OP_I == fsch_pkg::OP_ERAS) begin
          nxt_esusp = 1'b1;
          nxt_susp = 1'b1;
        end else if (ENG_BUSY_I && ENG_OP_I == fsch_pkg::OP_PROG) begin
          nxt_psusp = 1'b1;
          nxt_susp = 1'b1;
        end
        nxt_wel = 1'b0;
      end
      fsch_pkg::CMD_RESUME: begin
        // Nested suspend: program resumes first, then the erase
        if (psusp_ff) begin
          nxt_psusp = 1'b0;
        end else begin
          nxt_esusp = 1'b0;
        end
        nxt_resm = psusp_ff | esusp_ff;
      end
      default: ;
    endcase
    if (ENG_DONE_I) begin
      nxt_wel = 1'b0;
    end
    if (cfg_wr) begin
      nxt_pincfg = AVS_WRITEDATA_I[fsch_pkg::CF_PINCFG];
      nxt_protect_pin_enable = AVS_WRITEDATA_I[fsch_pkg::CF_PROTECT_PIN_ENABLE];
      nxt_wel = 1'b0;
      if (AVS_WRITEDATA_I[fsch_pkg::CF_PROTECT_PIN_ENABLE] != protect_pin_enable_ff) begin
        nxt_tmr = fsch_pkg::TMR_W'(fsch_pkg::PROTECT_PIN_ENABLE_CYC);
      end
    end
  end

  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      wel_ff <= 1'b0;
      esusp_ff <= 1'b0;
      psusp_ff <= 1'b0;
      lkdn_ff <= 1'b0;
      sec_ff <= 1'b0;
      pincfg_ff <= 1'b0;
      protect_pin_enable_ff <= 1'b0;
      noperm_ff <= 1'b1;
      init_ff <= 1'b0;
      susp_ff <= 1'b0;
      resm_ff <= 1'b0;
      tmr_ff <= '0;
    end else begin
      wel_ff <= nxt_wel;
      esusp_ff <= nxt_esusp;
      psusp_ff <= nxt_psusp;
      lkdn_ff <= nxt_lkdn;
      sec_ff <= nxt_sec;
      pincfg_ff <= nxt_pincfg;
      protect_pin_enable_ff <= nxt_protect_pin_enable;
      noperm_ff <= nxt_noperm;
      init_ff <= nxt_init;
      susp_ff <= nxt_susp;
      resm_ff <= nxt_resm;
      tmr_ff <= nxt_tmr;
    end
  end

  always_comb begin
    status_b = 8'h00;
    status_b[fsch_pkg::ST_BUSY0] = busy;
    status_b[fsch_pkg::ST_BUSY7] = busy;
    status_b[fsch_pkg::ST_WEL] = wel_ff;
    status_b[fsch_pkg::ST_ESUSP] = esusp_ff;
    status_b[fsch_pkg::ST_PSUSP] = psusp_ff;
    status_b[fsch_pkg::ST_LKDN] = lkdn_ff;
    status_b[fsch_pkg::ST_SEC] = sec_ff;
    config_b = 8'h00;
    config_b[fsch_pkg::CF_PINCFG] = pincfg_ff;
    config_b[fsch_pkg::CF_NOPERM] = noperm_ff;
    config_b[fsch_pkg::CF_PROTECT_PIN_ENABLE] = protect_pin_enable_ff;
  end

  assign WRITE_ALLOW_O = wel_ff;
  assign QUAD_ALLOW_O = pincfg_ff;
  assign SUSPEND_O = susp_ff;
  assign RESUME_O = resm_ff;
  assign SEC_O = sec_ff;
  assign PROTECT_PIN_ENABLE_O = protect_pin_enable_ff;

  // ***************
  // Secure id space
  // ***************
  // Reset-loaded so a read never shows unknowns; program only clears bits
  logic [7:0] sid_mem [fsch_pkg::SID_BYTES];
  logic [fsch_pkg::SID_AW-1:0] sid_ra_ff, nxt_sid_ra;

  always_comb begin
    nxt_sid_ra = (cmd != fsch_pkg::CMD_NONE) ? cmd_addr : sid_ra_ff;
  end

  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      sid_ra_ff <= '0;
      for (int i = 0; i < fsch_pkg::SID_BYTES; i++) begin
        sid_mem[i] <= (i < 8) ? FACTORY_UID[8*i +: 8] : fsch_pkg::SID_BLANK;
      end
    end else begin
      sid_ra_ff <= nxt_sid_ra;
      if (sid_ok) begin
        sid_mem[cmd_addr] <= sid_mem[cmd_addr] & cmd_data;
      end
    end
  end
  assign sid_q = sid_mem[sid_ra_ff];

  // ***************
  // Hold pause
  // ***************
  fsch_pkg::fsch_pins_t s1_ff, s2_ff, s3_ff;
  fsch_pkg::fsch_hold_t hs_ff, nxt_hs;
  logic hold_en;
  logic so_ff, nxt_so, oe_ff, nxt_oe;
  logic rise_ff, nxt_rise, rst_ff, nxt_rst, si_ff;

  // Pins are async to CLK_I: two flops before any logic looks
  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      s1_ff <= 4'hF;
      s2_ff <= 4'hF;
      s3_ff <= 4'hF;
    end else begin
      s1_ff <= {SPI_CE_N_I, SPI_SCK_I, SPI_HOLD_N_I, SPI_SI_I};
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
    end
  end

  assign hold_en = ~pincfg_ff & ~QUAD_MODE_I;

  always_comb begin
    nxt_hs = hs_ff;
    case (hs_ff)
      fsch_pkg::HS_RUN: begin
        if (hold_en && !s2_ff.ce_n && !s2_ff.sck && !s2_ff.hold_n) begin
          nxt_hs = fsch_pkg::HS_PAUSE;
        end
      end
      fsch_pkg::HS_PAUSE: begin
        if (!hold_en) begin
          nxt_hs = fsch_pkg::HS_RUN;
        end else if (s2_ff.ce_n && s2_ff.hold_n) begin
          nxt_hs = fsch_pkg::HS_RUN;
        end else if (!s2_ff.ce_n && !s2_ff.sck && s2_ff.hold_n) begin
          nxt_hs = fsch_pkg::HS_RUN;
        end
      end
      default: nxt_hs = fsch_pkg::HS_RUN;
    endcase
    nxt_rst = s2_ff.ce_n & ~s3_ff.ce_n;
    nxt_rise = s2_ff.sck & ~s3_ff.sck & ~s2_ff.ce_n & (hs_ff == fsch_pkg::HS_RUN);
    nxt_oe = SO_DRIVE_I & ~s2_ff.ce_n & (nxt_hs == fsch_pkg::HS_RUN);
    nxt_so = SO_DATA_I;
  end

  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      hs_ff <= fsch_pkg::HS_RUN;
      so_ff <= 1'b0;
      oe_ff <= 1'b0;
      rise_ff <= 1'b0;
      rst_ff <= 1'b0;
      si_ff <= 1'b0;
    end else begin
      hs_ff <= nxt_hs;
      so_ff <= nxt_so;
      oe_ff <= nxt_oe;
      rise_ff <= nxt_rise;
      rst_ff <= nxt_rst;
      si_ff <= s2_ff.si;
    end
  end

  assign HOLD_ACTIVE_O = (hs_ff == fsch_pkg::HS_PAUSE);
  assign SPI_SO_O = so_ff;
  assign SPI_SO_OE_O = oe_ff;
  assign SCK_RISE_O = rise_ff;
  assign IF_RESET_O = rst_ff;
  assign SI_O = si_ff;

  // ***************
  // Checks
  // ***************
  sequence s_lkdn_req;
    cmd == fsch_pkg::CMD_LOCKDN && wel_ff;
  endsequence
  sequence s_lkdn_seen;
    lkdn_ff && !wel_ff;
  endsequence

  a_busy_mirror: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    status_b[fsch_pkg::ST_BUSY0] == status_b[fsch_pkg::ST_BUSY7] && status_b[6] == 1'b0)
    else $error("busy copies differ or reserved set");
  a_lkdn_sticky: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    s_lkdn_req |=> s_lkdn_seen ##1 lkdn_ff[*3])
    else $error("lock-down not held");
  a_sec_never_clr: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    init_ff && $past(init_ff) && $past(sec_ff) |-> sec_ff)
    else $error("secure lock cleared");
  a_sid_locked: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    sec_ff |-> !sid_ok)
    else $error("program after lockout");
  a_sid_factory: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    sid_ok |-> cmd_addr >= fsch_pkg::SID_FACT_END)
    else $error("factory segment programmed");
  a_wel_refuse: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    cmd == fsch_pkg::CMD_LOCKDN && !wel_ff && !lkdn_ff |=> !lkdn_ff)
    else $error("lock-down without latch");
  a_wel_done: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    ENG_DONE_I |=> !wel_ff)
    else $error("latch kept after completion");
  a_protect_pin_enable_busy: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    cfg_wr && AVS_WRITEDATA_I[fsch_pkg::CF_PROTECT_PIN_ENABLE] != protect_pin_enable_ff |=> busy[*8])
    else $error("protect pin write not busy");
  a_hold_so_off: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    hs_ff == fsch_pkg::HS_PAUSE |-> !oe_ff && !rise_ff)
    else $error("output driven while paused");
  a_hold_quad_off: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    !hold_en |=> hs_ff == fsch_pkg::HS_RUN)
    else $error("pause in quad or pin mode");
  a_bus_answer: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    take |=> !wait_ff ##1 wait_ff)
    else $error("bus answer not one cycle");
endmodule

// File: fsch_top_test.sv
// Self-checking bench of fsch_top: registers, secure id, engine hooks, hold.
// Assumes fsch_pkg and fsch_host_model are compiled before it.
`timescale 1ns/1ns
module fsch_top_test;
  // ******
  // Signals
  // ******
  localparam logic [3:0] A_ST = fsch_pkg::ADR_STATUS;
  localparam logic [3:0] A_CF = fsch_pkg::ADR_CONFIG;
  localparam logic [3:0] A_ID = fsch_pkg::ADR_SID;
  logic        clk;
  logic        rst_n;
  logic        rd;
  logic        wr;
  logic        wt;
  logic [3:0]  adr;
  logic [31:0] wdat;
  logic [31:0] rdat;
  logic        quad, so_dat, so_drv, eng_busy, eng_done, perm, sec_nv, protect_pin_enable_nv;
  logic [1:0]  eng_op;
  logic        so, so_oe, si_o, sck_rise, if_rst, hold_act, quad_ok;
  logic        wr_ok, susp, resm, sec_o, protect_pin_enable_o;
  logic        so_exp, rst_q;
  logic [31:0] lfsr = 32'h000111F4;
  logic [10:0] a;
  logic [7:0]  sid [0:2047];
  int          error_cnt = 0;
  int          compares = 0;
  int          cyc = 0, n_rise = 0, n_ifr = 0, n_sus = 0, n_res = 0, r0;
  int          wen, lkd, sec, esus, psus, pin, wpn;
  fsch_pkg::fsch_pins_t pins;
  fsch_pkg::fsch_cmd_t  clr [3] = '{fsch_pkg::CMD_WRITE_DISABLE_CMD, fsch_pkg::CMD_WBPR, fsch_pkg::CMD_RESET};
  fsch_host_model u_host (
    .pins_o (pins)
  );
  fsch_top #(
    .FACTORY_UID (64'hA5A5A5A5A5A5A5A5)  // Arbitrary; one byte so order is moot
  ) u_dut (
    .CLK_I             (clk),
    .RST_N_I           (rst_n),
    .AVS_ADDRESS_I     (adr),
    .AVS_READ_I        (rd),
    .AVS_WRITE_I       (wr),
    .AVS_WRITEDATA_I   (wdat),
    .AVS_READDATA_O    (rdat),
    .AVS_WAITREQUEST_O (wt),
    .SPI_CE_N_I        (pins.ce_n),
    .SPI_SCK_I         (pins.sck),
    .SPI_HOLD_N_I      (pins.hold_n),
    .SPI_SI_I          (pins.si),
    .SPI_SO_O          (so),
    .SPI_SO_OE_O       (so_oe),
    .QUAD_MODE_I       (quad),
    .SO_DATA_I         (so_dat),
    .SO_DRIVE_I        (so_drv),
    .SI_O              (si_o),
    .SCK_RISE_O        (sck_rise),
    .IF_RESET_O        (if_rst),
    .HOLD_ACTIVE_O     (hold_act),
    .QUAD_ALLOW_O      (quad_ok),
    .ENG_BUSY_I        (eng_busy),
    .ENG_OP_I          (eng_op),
    .ENG_DONE_I        (eng_done),
    .PERM_LOCKED_I     (perm),
    .WRITE_ALLOW_O     (wr_ok),
    .SUSPEND_O         (susp),
    .RESUME_O          (resm),
    .SEC_NV_I          (sec_nv),
    .PROTECT_PIN_ENABLE_NV_I         (protect_pin_enable_nv),
    .SEC_O             (sec_o),
    .PROTECT_PIN_ENABLE_O            (protect_pin_enable_o)
  );
  // ******
  // Clock, pulse counters, timeout
  // ******
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc    <= cyc + 1;
    n_rise <= n_rise + (sck_rise === 1'b1);
    n_ifr  <= n_ifr + (if_rst === 1'b1);
    n_sus  <= n_sus + (susp === 1'b1);
    n_res  <= n_res + (resm === 1'b1);
    // Fresh random data out every cycle; the copy must trail it by one
    lfsr   <= lfsr_next(lfsr);
    so_dat <= lfsr[0];
    so_exp <= so_dat;
    rst_q  <= rst_n;
    if (rst_q === 1'b1) chk(so, so_exp);
    if (cyc == 20000) begin
      error_cnt = error_cnt + 1;
      print_verdict();
    end
  end
  // ******
  // Tasks and model
  // ******
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [7:0] est(input logic b);
    return {b, 1'h0, sec[0], lkd[0], psus[0], esus[0], wen[0], b};
  endfunction
  function automatic logic [7:0] ecf();
    return {wpn[0], 3'h0, ~perm, 1'h0, pin[0], 1'h0};
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Request held until waitrequest is seen low at an edge
  task automatic bus(input logic w, input logic [3:0] ad, input logic [31:0] d, output logic [31:0] q);
    @(posedge clk);
    adr  <= ad;
    wdat <= d;
    rd   <= ~w;
    wr   <= w;
    do @(posedge clk); while (wt !== 1'b0);
    q = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  task automatic rd_chk(input logic [3:0] ad, input logic [7:0] e);
    logic [31:0] q;
    bus(1'b0, ad, 32'h0, q);
    chk(q, {24'h0, e});
  endtask
  task automatic wr_reg(input logic [3:0] ad, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, ad, d, q);
  endtask
  task automatic poll();
    logic [31:0] q;
    do bus(1'b0, A_ST, 32'h0, q); while (q[0] !== 1'b0);
  endtask
  task automatic cmd(input fsch_pkg::fsch_cmd_t c, input logic [10:0] ad = 11'h0, input logic [7:0] d = 8'h0);
    int ok;
    int keep;
    ok = wen;
    // A refused id program and a resume leave the latch alone
    keep = (c == fsch_pkg::CMD_WREN || c == fsch_pkg::CMD_RESUME);
    wr_reg(fsch_pkg::ADR_CMD, {d, 5'h0, ad, 4'h0, c});
    case (c)
      fsch_pkg::CMD_WREN:    wen = 1;
      fsch_pkg::CMD_LOCKDN:  lkd |= ok;
      fsch_pkg::CMD_LOCKOUT_SECURE_ID_CMD:    sec |= ok;
      fsch_pkg::CMD_PROGRAM_SECURE_ID_CMD:    if (ok && !sec && ad >= 8) sid[ad] &= d; else keep = 1;
      fsch_pkg::CMD_SUSPEND: begin
        esus |= (eng_busy && eng_op == 2'h2);
        psus |= (eng_busy && eng_op == 2'h1);
      end
      fsch_pkg::CMD_RESUME:  if (psus) psus = 0; else esus = 0;
      default: ;
    endcase
    if (!keep) wen = 0;
  endtask
  task automatic do_reset();
    rst_n <= 1'b0;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    {wen, lkd, esus, psus, pin} = 160'h0;
    sec = sec_nv;
    wpn = protect_pin_enable_nv;
    foreach (sid[i]) sid[i] = (i < 8) ? 8'hA5 : 8'hFF;
  endtask
  task automatic settle();
    repeat (6) @(posedge clk);
  endtask
  task automatic print_verdict();
    if (error_cnt == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // ******
  // Main sequence
  // ******
  initial begin
    rst_n = 1'b0;
    {rd, wr, adr, wdat} = 38'h0;
    {quad, eng_busy, eng_done, perm, sec_nv, protect_pin_enable_nv, eng_op} = 8'h0;
    so_drv = 1'b1;
    do_reset();
    rd_chk(A_ST, est(1'h0));
    rd_chk(A_CF, ecf());
    rd_chk(4'h2, 8'h00);
    wr_reg(A_ST, 32'h000000FF);
    rd_chk(A_ST, est(1'h0));
    cmd(fsch_pkg::CMD_LOCKDN);
    rd_chk(A_ST, est(1'h0));
    foreach (clr[i]) begin
      cmd(fsch_pkg::CMD_WREN);
      rd_chk(A_ST, est(1'h0));
      chk(wr_ok, 1'h1);
      cmd(clr[i]);
      rd_chk(A_ST, est(1'h0));
    end
    cmd(fsch_pkg::CMD_WREN);
    cmd(fsch_pkg::CMD_LOCKDN);
    rd_chk(A_ST, est(1'h0));
    cmd(fsch_pkg::CMD_WREN);
    r0 = cyc;
    wr_reg(A_CF, 32'hFFFFFFFF);
    wen = 0;
    pin = 1;
    wpn = 1;
    rd_chk(A_ST, est(1'h1));
    rd_chk(A_CF, ecf());
    chk(quad_ok, 1'h1);
    chk(protect_pin_enable_o, 1'h1);
    poll();
    chk((cyc - r0) inside {[100:120]}, 1'h1);
    rd_chk(A_ST, est(1'h0));
    wr_reg(A_CF, 32'h0);
    pin = 0;
    wpn = 0;
    poll();
    // Secure id: factory bytes fixed, user bytes one-way programmable
    // Code zero is no command at all, so the enable command carries the address
    cmd(fsch_pkg::CMD_WREN, 11'h007);
    rd_chk(A_ID, sid[7]);
    cmd(fsch_pkg::CMD_WREN);
    cmd(fsch_pkg::CMD_PROGRAM_SECURE_ID_CMD, 11'h003, 8'h00);
    rd_chk(A_ID, sid[3]);
    for (int i = 0; i < 5; i++) begin
      a = 11'h008 + 11'(lfsr[15:0] % 16'h07F8);
      cmd(fsch_pkg::CMD_WREN, a);
      rd_chk(A_ID, sid[a]);
      cmd(fsch_pkg::CMD_PROGRAM_SECURE_ID_CMD, a, lfsr[31:24]);
      rd_chk(A_ID, sid[a]);
    end
    cmd(fsch_pkg::CMD_WREN);
    cmd(fsch_pkg::CMD_LOCKOUT_SECURE_ID_CMD);
    rd_chk(A_ST, est(1'h0));
    chk(sec_o, 1'h1);
    cmd(fsch_pkg::CMD_WREN);
    cmd(fsch_pkg::CMD_PROGRAM_SECURE_ID_CMD, a, 8'h00);
    rd_chk(A_ID, sid[a]);
    // Suspend and resume of erase, then program
    for (int op = 2; op > 0; op--) begin
      eng_op   <= 2'(op);
      eng_busy <= 1'b1;
      rd_chk(A_ST, est(1'h1));
      cmd(fsch_pkg::CMD_WREN);
      r0 = n_sus + n_res;
      cmd(fsch_pkg::CMD_SUSPEND);
      eng_busy <= 1'b0;
      rd_chk(A_ST, est(1'h0));
      cmd(fsch_pkg::CMD_RESUME);
      rd_chk(A_ST, est(1'h0));
      chk(n_sus + n_res - r0, 32'h2);
    end
    cmd(fsch_pkg::CMD_WREN);
    eng_done <= 1'b1;
    @(posedge clk);
    eng_done <= 1'b0;
    wen = 0;
    rd_chk(A_ST, est(1'h0));
    // Hold pause on the link
    u_host.sel(1'b0);
    r0 = n_rise;
    u_host.tick(4);
    settle();
    chk(n_rise - r0, 32'h4);
    chk(so_oe, 1'h1);
    chk(si_o, pins.si);
    u_host.set_hold(1'b0);
    settle();
    chk({hold_act, so_oe}, 2'h2);
    r0 = n_rise;
    u_host.tick(3);
    settle();
    chk(n_rise - r0, 32'h0);
    u_host.set_hold(1'b1);
    settle();
    chk({hold_act, so_oe}, 2'h1);
    // Clock stalled high: hold edges wait for clock low
    u_host.set_sck(1'b1);
    u_host.set_hold(1'b0);
    settle();
    chk(hold_act, 1'h0);
    u_host.set_sck(1'b0);
    settle();
    chk(hold_act, 1'h1);
    u_host.set_sck(1'b1);
    u_host.set_hold(1'b1);
    settle();
    chk(hold_act, 1'h1);
    u_host.set_sck(1'b0);
    settle();
    chk(hold_act, 1'h0);
    u_host.set_hold(1'b0);
    settle();
    r0 = n_ifr;
    u_host.sel(1'b1);
    settle();
    chk(n_ifr - r0, 32'h1);
    chk(hold_act, 1'h1);
    u_host.rejoin();
    settle();
    chk(hold_act, 1'h0);
    quad <= 1'b1;
    u_host.set_hold(1'b0);
    settle();
    chk(hold_act, 1'h0);
    u_host.set_hold(1'b1);
    quad <= 1'b0;
    wr_reg(A_CF, 32'h2);
    u_host.set_hold(1'b0);
    settle();
    chk(hold_act, 1'h0);
    u_host.set_hold(1'b1);
    u_host.sel(1'b1);
    // Second power-up with stored bits and a permanent lock
    {sec_nv, protect_pin_enable_nv, perm} <= 3'h7;
    do_reset();
    rd_chk(A_ST, est(1'h0));
    rd_chk(A_CF, ecf());
    print_verdict();
  end
endmodule
